// *** hdl/rtc_trim_defs.svh ***
/*
  Shared constants of the RTC source select and RC trim link.
  Assumes it is included by bare name from the package and the design files.
*/
`ifndef RTC_TRIM_DEFS_SVH
`define RTC_TRIM_DEFS_SVH

// Width of a serial command word
`define CMD_W 8
// Last bit index of a command word
`define CMD_LAST 4'h7
// Direct command that starts RC oscillator trimming
`define CMD_TRIM_OSC 8'hC2
// Number of reference clock edges of one calibration
`define REF_EDGES 7'h41
// Index of the last reference edge (counted from zero)
`define REF_LAST 7'h40
// Width of the calibration word
`define TRIM_W 16
// Saturation value of the calibration word
`define TRIM_MAX 16'hFFFF
// Host: mclk cycles per half period of the serial clock
`define SCLK_HALF 4'h2
// Host: mclk cycles per half period of the external RTC clock
`define EXT_HALF 4'h3
// Host: chip select stays high this many mclk cycles plus one after the last edge
`define CS_HOLD 4'h4
// Host: serial clock rises that carry one command word
`define CMD_BITS 7'h08
// Width of the small host counters
`define CNT_W 4

`endif

// *** hdl/rtc_trim_device.sv ***
/*
  RTC device end: source select and RC oscillator trimming.
  Command decode and reference counting run on the serial clock, which
  stands still outside frames; chip select low clears that logic. The
  core side runs on mclk and models the RC oscillator as a divider.
  Assumes the host holds chip select high for at least three mclk cycles
  after the last reference edge, so the result can be taken over.
*/
`timescale 1ns/10ps
`include "rtc_trim_defs.svh"

// Function
// - Bit zero selects crystal path or RC
// - Trim starts only on trim command
// - Host: CS, command, 65 clocks, CS low
// - Result applied at 65th reference edge
// - Result volatile, lost on RC off/reset
// - Host enables crystal path for external clock
// - Host holds external clock high in power-down
// - Reference near quarter of carrier frequency
module rtc_trim_device (
  rtc_trim_if.device link,
  input wire logic mclk,
  input wire logic reset,
  input wire logic rc_osc_on,
  output logic rtc_from_xtal,
  output logic rtc_level,
  output logic [`TRIM_W-1:0] trim_word,
  output logic trim_valid
);

  // Link clock state and its next value
  rtc_trim_pkg::dev_link_t link_reg;
  rtc_trim_pkg::dev_link_t link_next;
  // Core clock state and its next value
  rtc_trim_pkg::dev_core_t core_reg;
  rtc_trim_pkg::dev_core_t core_next;
  // Command word as it stands after the current bit
  logic [`CMD_W-1:0] cmd_word;

  assign cmd_word = {link_reg.shreg[`CMD_W-2:0], link.serial_host_port_data};

  // Next state of the link side
  always_comb begin
    link_next = link_reg;
    // RC level is an mclk flop; two flops before any use
    link_next.rc_sync = {link_reg.rc_sync[0], core_reg.rc_level};
    link_next.rc_prev = link_reg.rc_sync[1];
    case (link_reg.state)
      rtc_trim_pkg::L_CMD: begin
        // Shift command bits in, MSB first
        link_next.shreg = cmd_word;
        link_next.bit_cnt = link_reg.bit_cnt + 4'h1;
        if (link_reg.bit_cnt == `CMD_LAST) begin
          if (cmd_word == `CMD_TRIM_OSC) begin
            // Only this command opens the reference phase
            link_next.state = rtc_trim_pkg::L_REF;
            link_next.edge_cnt = 7'h00;
            link_next.tick_cnt = '0;
          end else begin
            // Other commands are not ours; sit out the frame
            link_next.state = rtc_trim_pkg::L_IGNORE;
          end
        end
      end
      rtc_trim_pkg::L_REF: begin
        // Each rising sclk edge here is one reference edge
        link_next.edge_cnt = link_reg.edge_cnt + 7'h01;
        // RC ticks counted from the first edge on, i.e. over 64 periods
        if ((link_reg.edge_cnt != 7'h00) && link_reg.rc_sync[1] &&
            !link_reg.rc_prev && (link_reg.tick_cnt != `TRIM_MAX)) begin
          link_next.tick_cnt = link_reg.tick_cnt + 16'h0001;
        end
        if (link_reg.edge_cnt == `REF_LAST) begin
          // 65th edge: result complete, never waits longer
          link_next.cal_done = 1'b1;
          link_next.state = rtc_trim_pkg::L_DONE;
        end
      end
      rtc_trim_pkg::L_DONE: begin
        // Extra edges in the same frame do not retrim
        link_next.state = rtc_trim_pkg::L_DONE;
      end
      rtc_trim_pkg::L_IGNORE: begin
        // Hold until chip select ends the frame
        link_next.state = rtc_trim_pkg::L_IGNORE;
      end
      default: begin
        link_next.state = rtc_trim_pkg::L_IGNORE;
      end
    endcase
  end

  // Link side register. The serial clock stops between frames, so no
  // clocked reset could ever act there; chip select low clears it at
  // once and the next frame starts in command decode.
  always_ff @(posedge link.sclk or negedge link.cs) begin
    if (!link.cs) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // Next state of the core side
  always_comb begin
    core_next = core_reg;
    // Level crossings from the link and from pins, two flops each
    core_next.done_sync = {core_reg.done_sync[0], link_reg.cal_done};
    core_next.done_prev = core_reg.done_sync[1];
    core_next.src_sync = {core_reg.src_sync[0], link.cfg1_src_xtal};
    core_next.ext_sync = {core_reg.ext_sync[0], link.osc_input_pin};
    // RC oscillator stand-in: runs only while switched on
    if (rc_osc_on) begin
      core_next.rc_level = ~core_reg.rc_level;
    end else begin
      core_next.rc_level = 1'b0;
    end
    if (!rc_osc_on) begin
      // Switching the oscillator off loses the trim
      core_next.trim_word = '0;
      core_next.trim_valid = 1'b0;
    end else if (core_reg.done_sync[1] && !core_reg.done_prev) begin
      // Done has risen here; the word has been still since before it
      core_next.trim_word = link_reg.tick_cnt;
      core_next.trim_valid = 1'b1;
    end
    // RTC source: crystal path on bit zero set, RC otherwise
    core_next.rtc_from_xtal = core_reg.src_sync[1];
    if (core_reg.src_sync[1]) begin
      core_next.rtc_level = core_reg.ext_sync[1];
    end else begin
      core_next.rtc_level = core_reg.rc_level;
    end
  end

  // Core register; a reset stands for power-on and wipes the trim
  always_ff @(posedge mclk) begin
    if (reset) begin
      core_reg <= '0;
    end else begin
      core_reg <= core_next;
    end
  end

  // Outputs straight from flops
  assign rtc_from_xtal = core_reg.rtc_from_xtal;
  assign rtc_level = core_reg.rtc_level;
  assign trim_word = core_reg.trim_word;
  assign trim_valid = core_reg.trim_valid;

  // Notes for users of this end:
  // The trim word is a count of RC ticks over 64 reference periods;
  // an analog trim DAC would take it, here it is only reported.
  // The RC level is sampled on the serial clock, so the serial clock
  // must be well above twice the RC rate for an exact count.
  // The crystal enable bit is carried on the link but does not steer
  // the source; only bit zero does, which keeps one source of truth.
  // A trim command in a frame whose host drops chip select early
  // leaves the last good word in place, since done never rises.

endmodule // rtc_trim_device

// *** hdl/rtc_trim_host.sv ***
/*
  Host end: drives chip select, the trim command, the reference clock,
  the RTC configuration bits and the external RTC clock.
  Assumes start_trim, use_ext_clk, sel_xtal and power_down are mclk
  signals; the serial clock is derived from mclk by a divider.
*/
`timescale 1ns/10ps
`include "rtc_trim_defs.svh"

module rtc_trim_host (
  rtc_trim_if.host link,
  input wire logic mclk,
  input wire logic reset,
  input wire logic start_trim,
  input wire logic use_ext_clk,
  input wire logic sel_xtal,
  input wire logic power_down,
  output logic busy,
  output logic done
);

  // Whole host state and its next value
  rtc_trim_pkg::host_t host_reg;
  rtc_trim_pkg::host_t host_next;
  // Half period of the serial clock has elapsed
  logic half_tick;

  // The reference rate is fixed by this divider; choose mclk so that it
  // lands near a quarter of the carrier frequency
  assign half_tick = (host_reg.div_cnt == `SCLK_HALF - 4'h1);

  // Next state
  always_comb begin
    host_next = host_reg;
    host_next.done = 1'b0;
    // External clock path needs the crystal path enabled
    host_next.src_xtal = sel_xtal | use_ext_clk;
    host_next.xtal_en = sel_xtal | use_ext_clk;
    // External clock: parked high in power-down or when unused
    if (power_down || !use_ext_clk) begin
      host_next.osc_in = 1'b1;
      host_next.ext_cnt = '0;
    end else if (host_reg.ext_cnt == `EXT_HALF - 4'h1) begin
      host_next.osc_in = ~host_reg.osc_in;
      host_next.ext_cnt = '0;
    end else begin
      host_next.ext_cnt = host_reg.ext_cnt + 4'h1;
    end
    // Divider runs only during a frame
    if (host_reg.state == rtc_trim_pkg::H_IDLE || half_tick) begin
      host_next.div_cnt = '0;
    end else begin
      host_next.div_cnt = host_reg.div_cnt + 4'h1;
    end
    case (host_reg.state)
      rtc_trim_pkg::H_IDLE: begin
        if (start_trim) begin
          // Chip select first, first bit ready before the first rise
          host_next.state = rtc_trim_pkg::H_CMD;
          host_next.cs = 1'b1;
          host_next.cmd_sh = `CMD_TRIM_OSC;
          host_next.sdata = host_next.cmd_sh[`CMD_W-1];
          host_next.edge_cnt = 7'h00;
        end
      end
      rtc_trim_pkg::H_CMD: begin
        if (half_tick) begin
          host_next.sclk = ~host_reg.sclk;
          if (!host_reg.sclk) begin
            host_next.edge_cnt = host_reg.edge_cnt + 7'h01;
          end else if (host_reg.edge_cnt == `CMD_BITS) begin
            // Command sent; reference edges follow
            host_next.state = rtc_trim_pkg::H_REF;
            host_next.edge_cnt = 7'h00;
            host_next.sdata = 1'b0;
          end else begin
            // New bit on the falling edge, device samples on the rise
            host_next.cmd_sh = {host_reg.cmd_sh[`CMD_W-2:0], 1'b0};
            host_next.sdata = host_reg.cmd_sh[`CMD_W-2];
          end
        end
      end
      rtc_trim_pkg::H_REF: begin
        if (half_tick) begin
          host_next.sclk = ~host_reg.sclk;
          if (!host_reg.sclk) begin
            host_next.edge_cnt = host_reg.edge_cnt + 7'h01;
          end else if (host_reg.edge_cnt == `REF_EDGES) begin
            // 65 reference cycles given; hold CS a little
            host_next.state = rtc_trim_pkg::H_HOLD;
            host_next.edge_cnt = 7'h00;
          end
        end
      end
      rtc_trim_pkg::H_HOLD: begin
        host_next.edge_cnt = host_reg.edge_cnt + 7'h01;
        if (host_reg.edge_cnt == {3'h0, `CS_HOLD}) begin
          // Only now does chip select drop
          host_next.state = rtc_trim_pkg::H_IDLE;
          host_next.cs = 1'b0;
          host_next.done = 1'b1;
        end
      end
      default: begin
        host_next.state = rtc_trim_pkg::H_IDLE;
        host_next.cs = 1'b0;
      end
    endcase
  end

  // Single state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      host_reg <= '0;
    end else begin
      host_reg <= host_next;
    end
  end

  // Pins and user outputs straight from flops
  assign link.cs = host_reg.cs;
  assign link.sclk = host_reg.sclk;
  assign link.serial_host_port_data = host_reg.sdata;
  assign link.cfg1_src_xtal = host_reg.src_xtal;
  assign link.cfg1_xtal_en = host_reg.xtal_en;
  assign link.osc_input_pin = host_reg.osc_in;
  assign busy = host_reg.cs;
  assign done = host_reg.done;

endmodule // rtc_trim_host

// *** hdl/rtc_trim_if.sv ***
/*
  Pins between the host controller and the RTC device.
  Assumes the host drives every signal; the device only listens.
*/
`timescale 1ns/10ps

interface rtc_trim_if;
  logic cs;                     // Chip select, high during a frame
  logic sclk;                   // Serial clock, also the trim reference
  logic serial_host_port_data;  // Command bits, sampled on sclk rise
  logic cfg1_src_xtal;          // Config register one bit 0: RTC source
  logic cfg1_xtal_en;           // Config register one bit 1: crystal path on
  logic osc_input_pin;          // External RTC clock

  modport host (
    output cs,
    output sclk,
    output serial_host_port_data,
    output cfg1_src_xtal,
    output cfg1_xtal_en,
    output osc_input_pin
  );

  modport device (
    input cs,
    input sclk,
    input serial_host_port_data,
    input cfg1_src_xtal,
    input cfg1_xtal_en,
    input osc_input_pin
  );
endinterface

// *** hdl/rtc_trim_pkg.sv ***
/*
  Types shared by both ends of the RTC trim link.
  Assumes rtc_trim_defs.svh is on the include path.
*/
`include "rtc_trim_defs.svh"

package rtc_trim_pkg;

  // Link side of the device
  typedef enum logic [1:0] {
    L_CMD = 2'b00,
    L_REF = 2'b01,
    L_DONE = 2'b10,
    L_IGNORE = 2'b11
  } link_state_t;

  // Host sequencer
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_CMD = 2'b01,
    H_REF = 2'b10,
    H_HOLD = 2'b11
  } host_state_t;

  // Device state on the link clock
  typedef struct packed {
    link_state_t state;
    logic [3:0] bit_cnt;
    logic [`CMD_W-1:0] shreg;
    logic [6:0] edge_cnt;
    logic [1:0] rc_sync;
    logic rc_prev;
    logic [`TRIM_W-1:0] tick_cnt;
    logic cal_done;
  } dev_link_t;

  // Device state on mclk
  typedef struct packed {
    logic [1:0] done_sync;
    logic done_prev;
    logic [1:0] src_sync;
    logic [1:0] ext_sync;
    logic rc_level;
    logic [`TRIM_W-1:0] trim_word;
    logic trim_valid;
    logic rtc_from_xtal;
    logic rtc_level;
  } dev_core_t;

  // Host state on mclk
  typedef struct packed {
    host_state_t state;
    logic cs;
    logic sclk;
    logic sdata;
    logic [`CMD_W-1:0] cmd_sh;
    logic [`CNT_W-1:0] div_cnt;
    logic [6:0] edge_cnt;
    logic [`CNT_W-1:0] ext_cnt;
    logic osc_in;
    logic src_xtal;
    logic xtal_en;
    logic done;
  } host_t;

endpackage

// *** verification/rtc_trim_sva.sv ***
/*
  Checker of the pins that the host drives on the joined RTC trim link.
  Assumes every pin comes from an mclk flop of the host end.
*/
`timescale 1ns/10ps
`include "rtc_trim_defs.svh"

module rtc_trim_sva (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cs,
  input wire logic sclk,
  input wire logic serial_host_port_data,
  input wire logic cfg1_src_xtal,
  input wire logic cfg1_xtal_en,
  input wire logic osc_input_pin
);
  localparam logic [7:0] trim_cmd = `CMD_TRIM_OSC; // Expected command word
  logic [6:0] rise_reg; // Serial clock rises seen in this frame
  logic sclk_reg; // Serial clock one cycle back
  logic rst_reg; // Reset one cycle back, masks the release edge

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Count rises per frame; the total survives the fall of cs for one edge
  always_ff @(posedge mclk) begin
    sclk_reg <= sclk;
    rst_reg <= reset;
    if (reset || !cs) begin
      rise_reg <= 7'h00;
    end else if (sclk && !sclk_reg) begin
      rise_reg <= rise_reg + 7'h01;
    end
  end

  idle_clock_low_a: assert property (!cs |-> !sclk)
    else $error("serial clock moves outside a frame");
  frame_start_a: assert property ($rose(cs) |-> !sclk ##2 sclk)
    else $error("first serial clock rise misplaced");
  clock_shape_a: assert property ($rose(sclk) |-> sclk ##1 sclk ##1 !sclk)
    else $error("serial clock high time wrong");
  data_hold_a: assert property ($rose(sclk) |=> $stable(serial_host_port_data))
    else $error("command bit changes while clock high");
  cmd_bits_a: assert property ($rose(sclk) && rise_reg < 7'h08 |->
    serial_host_port_data == trim_cmd[~rise_reg[2:0]])
    else $error("trim command bit wrong");
  edge_total_a: assert property ($fell(cs) |-> rise_reg == 7'h49)
    else $error("frame does not carry command plus 65 edges");
  cs_hold_a: assert property ($fell(sclk) && rise_reg == 7'h49 |->
    cs [*3] ##[1:6] !cs)
    else $error("chip select hold after last edge wrong");
  src_pair_a: assert property (cfg1_src_xtal |-> cfg1_xtal_en)
    else $error("crystal source without crystal path");
  ext_idle_a: assert property (!rst_reg && !cfg1_xtal_en && !$past(cfg1_xtal_en)
    |-> osc_input_pin)
    else $error("unused external clock not high");
  ext_half_a: assert property ($rose(osc_input_pin) |=> osc_input_pin [*2])
    else $error("external clock high half too short");

  frame_c: cover property ($fell(cs) && rise_reg == 7'h49);
  ext_clock_c: cover property ($fell(osc_input_pin));
  xtal_src_c: cover property ($rose(cfg1_src_xtal));
endmodule // rtc_trim_sva

// *** verification/tb_rtc_source_select_rc_trim.sv ***
/*
  Testbench: host and device joined on one link, plus a second device fed
  by hand-made frames on a 12 ns link clock.
  Assumes the design files and rtc_trim_defs.svh are compiled first.
*/
`timescale 1ns/10ps
`include "rtc_trim_defs.svh"

module tb_rtc_source_select_rc_trim;
  logic mclk, reset, rc_osc_on, start_trim, use_ext_clk, sel_xtal, power_down;
  logic busy, done, rtc_from_xtal, rtc_level, trim_valid, rtc_from_xtal_b;
  logic rtc_level_b, trim_valid_b;
  logic [`TRIM_W-1:0] trim_word, trim_word_b; // Results of both devices
  int fail_count, checks; // Mismatches and comparisons

  rtc_trim_if link_a(); // Host to device
  rtc_trim_if link_b(); // Bench to second device
  rtc_trim_host u_rtc_trim_host (.link(link_a), .mclk(mclk), .reset(reset),
    .start_trim(start_trim), .use_ext_clk(use_ext_clk), .sel_xtal(sel_xtal),
    .power_down(power_down), .busy(busy), .done(done));
  rtc_trim_device u_rtc_trim_device (.link(link_a), .mclk(mclk), .reset(reset),
    .rc_osc_on(rc_osc_on), .rtc_from_xtal(rtc_from_xtal), .rtc_level(rtc_level),
    .trim_word(trim_word), .trim_valid(trim_valid));
  rtc_trim_device u_rtc_trim_device_b (.link(link_b), .mclk(mclk), .reset(reset),
    .rc_osc_on(rc_osc_on), .rtc_from_xtal(rtc_from_xtal_b), .rtc_level(rtc_level_b),
    .trim_word(trim_word_b), .trim_valid(trim_valid_b));
  rtc_trim_sva u_rtc_trim_sva (.mclk(mclk), .reset(reset), .cs(link_a.cs),
    .sclk(link_a.sclk), .serial_host_port_data(link_a.serial_host_port_data),
    .cfg1_src_xtal(link_a.cfg1_src_xtal), .cfg1_xtal_en(link_a.cfg1_xtal_en),
    .osc_input_pin(link_a.osc_input_pin));

  // 20 MHz core clock
  always #25 mclk = ~mclk;

  // One comparison, counted; a mismatch is reported at once
  task check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask

  // Pulse start_trim for one cycle while the host is idle
  task start;
    @(negedge mclk);
    start_trim = 1'b1;
    @(negedge mclk);
    start_trim = 1'b0;
    check(busy === 1'b1, "busy missing after start");
  endtask

  // Bounded wait for the end of a frame; the result must already stand
  task wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 600) begin
      @(negedge mclk);
      n++;
    end
    check(done === 1'b1, "frame never ended");
    check(trim_valid === 1'b1, "no result at end of frame");
  endtask

  // Walk the three sources; the external clock must reach rtc_level
  task test_source;
    int n;
    logic prev; // RTC level at the previous falling edge
    for (int i = 0; i < 3; i++) begin
      @(negedge mclk);
      sel_xtal = (i == 1);
      use_ext_clk = (i == 2);
      repeat (8) @(negedge mclk);
      check(rtc_from_xtal === (i != 0), "source select");
      check(link_a.cfg1_xtal_en === (i != 0), "crystal path enable");
    end
    n = 0;
    prev = rtc_level;
    repeat (24) begin
      @(negedge mclk);
      n += (rtc_level !== prev);
      prev = rtc_level;
    end
    check(n >= 6, "external clock not selected");
    use_ext_clk = 1'b0;
    sel_xtal = 1'b0;
    $display("test source done");
  endtask

  // Plain trim with a second start while busy, which must be ignored
  task test_trim;
    int n;
    check(trim_valid === 1'b0, "result before any trim");
    start;
    repeat (20) @(negedge mclk);
    start_trim = 1'b1;
    @(negedge mclk);
    start_trim = 1'b0;
    wait_done;
    // The RC stand-in toggles every mclk and sclk rises every fourth mclk,
    // so every sample sees the same phase: no ticks are counted here
    check(trim_word === 16'h0000, "trim count");
    n = 0;
    repeat (350) begin
      @(negedge mclk);
      n += (done === 1'b1);
    end
    check(n == 0, "start while busy was taken");
    $display("test trim done");
  endtask

  // Result lost when the RC oscillator stops and on a reset after a finished trim
  task test_volatile;
    rc_osc_on = 1'b0;
    repeat (4) @(negedge mclk);
    check(trim_valid === 1'b0, "result kept with RC off");
    rc_osc_on = 1'b1;
    start;
    wait_done;
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    check(trim_valid === 1'b0, "result kept over reset");
    start;
    wait_done;
    $display("test volatile done");
  endtask

  // External clock must rest high in power-down
  task test_power_down;
    int n;
    use_ext_clk = 1'b1;
    repeat (10) @(negedge mclk);
    power_down = 1'b1;
    repeat (2) @(negedge mclk);
    n = 0;
    repeat (20) begin
      @(negedge mclk);
      n += (link_a.osc_input_pin !== 1'b1);
    end
    check(n == 0, "external clock moves in power-down");
    power_down = 1'b0;
    use_ext_clk = 1'b0;
    $display("test power down done");
  endtask

  // Hand-made frame: command, then n reference edges at 12 ns period
  task frame_b(input logic [7:0] cmd, input int n);
    link_b.cs = 1'b1;
    #20;
    for (int i = 0; i < 8 + n; i++) begin
      link_b.serial_host_port_data = (i < 8) ? cmd[7-i] : ~link_b.serial_host_port_data;
      #6 link_b.sclk = 1'b1;
      #6 link_b.sclk = 1'b0;
    end
    repeat (6) @(negedge mclk);
    link_b.cs = 1'b0;
    link_b.serial_host_port_data = ~link_b.serial_host_port_data;
    repeat (6) @(negedge mclk);
  endtask

  // Wrong command, aborted trim, extra edges, then abort keeps the old word
  task test_link_b;
    logic [`TRIM_W-1:0] kept;
    frame_b(8'h55, 65);
    check(trim_valid_b === 1'b0, "other command started a trim");
    frame_b(`CMD_TRIM_OSC, 30);
    check(trim_valid_b === 1'b0, "short trim gave a result");
    frame_b(`CMD_TRIM_OSC, 70);
    check(trim_valid_b === 1'b1, "trim after abort failed");
    check(trim_word_b >= 16'h0006 && trim_word_b <= 16'h000A, "link trim count");
    kept = trim_word_b;
    frame_b(`CMD_TRIM_OSC, 30);
    check(trim_word_b === kept, "aborted trim changed the word");
    $display("test link b done");
  endtask

  // Verdict and end of run
  task final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Main sequence; every input has a value at time zero
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    rc_osc_on = 1'b1;
    start_trim = 1'b0;
    use_ext_clk = 1'b0;
    sel_xtal = 1'b0;
    power_down = 1'b0;
    link_b.cs = 1'b0;
    link_b.sclk = 1'b0;
    link_b.serial_host_port_data = 1'b0;
    link_b.cfg1_src_xtal = 1'b0;
    link_b.cfg1_xtal_en = 1'b0;
    link_b.osc_input_pin = 1'b1;
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    test_source;
    test_trim;
    test_volatile;
    test_power_down;
    test_link_b;
    final_report;
  end

  // Watchdog: the tests need well under half of this span
  initial begin
    #1000000;
    fail_count++;
    $display("unexpected %0t watchdog expired", $time);
    final_report;
  end
endmodule // tb_rtc_source_select_rc_trim
